// ---- hdl/wdc_pkg.sv ----
// package: register map, field positions, reset values and timing counts of the watchdog
package wdc_pkg;
   // register byte offsets on the apb bus
   localparam logic [11:0] WDC_OFF_STATUS  = 12'h000;
   localparam logic [11:0] WDC_OFF_CONTROL = 12'h004;
   localparam logic [11:0] WDC_OFF_COUNT   = 12'h008;
   localparam logic [11:0] WDC_OFF_KEY     = 12'h00c;
   localparam logic [11:0] WDC_OFF_PROT    = 12'h010;
   // status register fields
   localparam int WDC_ST_UNLOCK  = 0;
   localparam int WDC_ST_IRQSEL  = 1;
   localparam int WDC_ST_IRQLVL  = 2;
   // control register fields
   localparam int WDC_CT_FLAG    = 7;
   localparam int WDC_CT_DIS     = 6;
   localparam int WDC_CT_CHK_HI  = 5;
   localparam int WDC_CT_CHK_LO  = 3;
   localparam int WDC_CT_PS_HI   = 2;
   localparam logic [2:0] WDC_CHECK_OK = 3'h5;
   // reset values
   localparam logic       WDC_RST_UNLOCK = 1'b1;
   localparam logic       WDC_RST_IRQSEL = 1'b0;
   localparam logic       WDC_RST_DIS    = 1'b0;
   localparam logic [2:0] WDC_RST_PS     = 3'h0;
   // service key values
   localparam logic [7:0] WDC_KEY_ARM    = 8'h55;
   localparam logic [7:0] WDC_KEY_CLEAR  = 8'haa;
   // timing counts in oscillator cycles
   localparam int WDC_BASE_DIV   = 512;
   localparam int WDC_PULSE_CYC  = 512;
   localparam int WDC_FLAG_DELAY = 4;
   localparam int WDC_SYNC_STAGES = 2;
endpackage

// ---- hdl/wdc_prescaler.sv ----
// file holds the counter clock prescaler: oscillator / 512 / 2^(code-1), with code 000 also oscillator / 512
`timescale 1ns/1ps
`default_nettype none
module wdc_prescaler #(
   parameter int DIV_BASE = wdc_pkg::WDC_BASE_DIV
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic [2:0] code,
   output logic            tick
);
   // free divider: 512 * 64 covers the deepest setting
   logic [14:0] div_q;
   logic [14:0] div_d;
   logic [14:0] limit;
   // codes 000 and 001 both divide by one after the base stage
   assign limit = (code == 3'h0) ? 15'(DIV_BASE - 1)
                : 15'((DIV_BASE << (code - 3'h1)) - 1);
   assign div_d = (div_q >= limit) ? 15'h0000 : 15'(div_q + 15'h0001);
   // divider stopped while the watchdog is disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 15'h0000;
         tick  <= 1'b0;
      end else if (!run) begin
         div_q <= 15'h0000;
         tick  <= 1'b0;
      end else begin
         div_q <= div_d;
         tick  <= (div_q >= limit);
      end
   end
endmodule
`default_nettype wire

// ---- hdl/wdc_top.sv ----
// file holds the watchdog control and status block with its apb slave
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module wdc_top #(
   parameter int PULSE_CYC = wdc_pkg::WDC_PULSE_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        device_reset_in_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             dog_reset_out_n,
   output logic             dog_irq_out_n,
   output logic [7:0]       dog_count
);
   // pulse engine states
   typedef enum logic [2:0] {
      WDC_IDLE  = 3'b001,
      WDC_RESET = 3'b010,
      WDC_IRQ   = 3'b100
   } wdc_state_e;

   wdc_state_e  state_q;                 // pulse engine state
   wdc_state_e  state_d;
   logic [9:0]  pulse_q;                 // pulse length counter
   logic        unlock_q;                // disable-unlock bit
   logic        irq_sel_q;               // irq select bit
   logic        dis_q;                   // watchdog disable bit
   logic [2:0]  ps_q;                    // counter prescale code
   logic        prot_q;                  // protected write enable
   logic        armed_q;                 // first key seen
   logic [1:0]  irq_sync_q;              // irq level synchroniser
   logic [1:0]  rst_sync_q;              // reset output synchroniser
   logic [3:0]  rst_dly_q;               // four-cycle delay line
   logic        flag_q;                  // watchdog reset flag
   logic        tick;                    // counter clock enable

   // apb decode; always ready, no wait states
   wire         acc       = psel && penable;
   wire         wr        = acc && pwrite && prot_q;
   wire         wr_any    = acc && pwrite;
   wire         hit_st    = (paddr == wdc_pkg::WDC_OFF_STATUS);
   wire         hit_ct    = (paddr == wdc_pkg::WDC_OFF_CONTROL);
   wire         hit_cnt   = (paddr == wdc_pkg::WDC_OFF_COUNT);
   wire         hit_key   = (paddr == wdc_pkg::WDC_OFF_KEY);
   wire         hit_prot  = (paddr == wdc_pkg::WDC_OFF_PROT);
   wire         mapped    = hit_st | hit_ct | hit_cnt | hit_key | hit_prot;
   wire         wr_st     = wr && hit_st;
   wire         wr_ct     = wr && hit_ct;
   wire         wr_key    = wr && hit_key;
   wire         running   = !dis_q;
   wire [2:0]   chk_in    = pwdata[wdc_pkg::WDC_CT_CHK_HI:wdc_pkg::WDC_CT_CHK_LO];
   // bad check pattern fires while enabled
   wire         chk_bad   = wr_ct && (chk_in != wdc_pkg::WDC_CHECK_OK) && running;
   wire [7:0]   key_in    = pwdata[7:0];
   wire         key_clear = wr_key && armed_q && (key_in == wdc_pkg::WDC_KEY_CLEAR);
   wire         key_bad   = wr_key && (key_in != wdc_pkg::WDC_KEY_CLEAR)
                            && (key_in != wdc_pkg::WDC_KEY_ARM) && running;
   wire         overflow  = tick && (dog_count == 8'hff);
   wire         timeout   = (overflow || key_bad) && running;
   wire         unlock_clr = wr_st && pwdata[wdc_pkg::WDC_ST_UNLOCK];
   wire         irq_low   = (state_q == WDC_IRQ);
   wire         pulse_end = (pulse_q == 10'(PULSE_CYC - 1));

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   // counter clock enable from the prescaler
   wdc_prescaler u_ps (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (running),
      .code    (ps_q),
      .tick    (tick)
   );

   // pulse engine: timeouts, pattern faults and mode switch
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         WDC_IDLE: begin
            if (chk_bad) state_d = WDC_RESET;
            else if (timeout) state_d = irq_sel_q ? WDC_IRQ : WDC_RESET;
         end
         WDC_RESET: begin
            if (pulse_end) state_d = WDC_IDLE;
         end
         WDC_IRQ: begin
            if (!irq_sel_q || chk_bad) state_d = WDC_RESET;
            else if (pulse_end) state_d = WDC_IDLE;
         end
      endcase
   end

   // state and pulse counter; counter restarts on each state change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= WDC_IDLE;
         pulse_q <= 10'h000;
      end else begin
         state_q <= state_d;
         pulse_q <= (state_d != state_q || state_q == WDC_IDLE) ? 10'h000
                    : 10'(pulse_q + 10'h001);
      end
   end

   // registered pin drivers, active low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dog_reset_out_n <= 1'b1;
         dog_irq_out_n   <= 1'b1;
      end else begin
         dog_reset_out_n <= (state_d != WDC_RESET);
         dog_irq_out_n   <= (state_d != WDC_IRQ);
      end
   end

   // 8-bit counter; cleared by valid key pair, and after each timeout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dog_count <= 8'h00;
         armed_q   <= 1'b0;
      end else begin
         if (key_clear || timeout) dog_count <= 8'h00;
         else if (tick) dog_count <= 8'(dog_count + 8'h01);
         if (wr_key) armed_q <= (key_in == wdc_pkg::WDC_KEY_ARM);
      end
   end

   // control fields written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_q  <= wdc_pkg::WDC_RST_UNLOCK;
         irq_sel_q <= wdc_pkg::WDC_RST_IRQSEL;
         dis_q     <= wdc_pkg::WDC_RST_DIS;
         ps_q      <= wdc_pkg::WDC_RST_PS;
         prot_q    <= 1'b0;
      end else begin
         // protect enable itself is never gated, else it could not be opened
         if (wr_any && hit_prot) prot_q <= pwdata[0];
         if (wr_st) irq_sel_q <= pwdata[wdc_pkg::WDC_ST_IRQSEL];
         if (unlock_clr) unlock_q <= 1'b0;
         if (unlock_clr) dis_q <= 1'b0;
         else if (wr_ct && unlock_q) dis_q <= pwdata[wdc_pkg::WDC_CT_DIS];
         if (wr_ct) ps_q <= pwdata[wdc_pkg::WDC_CT_PS_HI:0];
      end
   end

   // irq level synchroniser; first stage read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_sync_q <= 2'b11;
      end else begin
         irq_sync_q <= {irq_sync_q[0], dog_irq_out_n};
      end
   end

   // reset output synchroniser and four-cycle delay line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_sync_q <= 2'b11;
         rst_dly_q  <= 4'hf;
      end else begin
         rst_sync_q <= {rst_sync_q[0], dog_reset_out_n};
         rst_dly_q  <= {rst_dly_q[2:0], rst_sync_q[1]};
      end
   end

   // delayed rising edge of the reset output
   wire rst_rise = rst_dly_q[3] == 1'b0 && rst_dly_q[2] == 1'b1;

   // flag survives the block reset; the device reset pin or a control write with bit 7 set clears it
   always_ff @(posedge pclk or negedge device_reset_in_n) begin
      if (!device_reset_in_n) begin
         flag_q <= 1'b0;
      end else if (rst_rise) begin
         flag_q <= 1'b1;
      end else if (wr_ct && pwdata[wdc_pkg::WDC_CT_FLAG]) begin
         flag_q <= 1'b0;
      end
   end

   // read mux; check field zero, reserved zero
   wire [31:0] rd_st  = {29'h0, irq_sync_q[1], irq_sel_q, unlock_q};
   wire [31:0] rd_ct  = {24'h0, flag_q, dis_q, 3'h0, ps_q};
   wire [31:0] rd_cnt = {24'h0, dog_count};
   wire [31:0] rd_prt = {31'h0, prot_q};
   wire [31:0] rd_mux = hit_st  ? rd_st
                      : hit_ct  ? rd_ct
                      : hit_cnt ? rd_cnt
                      : hit_key ? rd_ct
                      : hit_prot ? rd_prt : 32'h0;

   // registered read data, loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0;
      else if (psel && !penable && !pwrite) prdata <= rd_mux;
   end
endmodule
`default_nettype wire

// ---- test/wdc_assertions.sv ----
// checker: port-level timing properties of the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module wdc_assertions #(
   parameter int PULSE_CYC = 8
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        device_reset_in_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        dog_reset_out_n,
   input wire logic        dog_irq_out_n,
   input wire logic [7:0]  dog_count
);
   logic [10:0] rlow_q;   // edges with reset output low
   logic [10:0] ilow_q;   // edges with irq output low
   wire logic   rd_set;   // read setup cycle
   wire logic   unmap;    // address outside the five words
   assign rd_set = psel && !penable && !pwrite;
   assign unmap = (paddr > 12'h010) || (paddr[1:0] != 2'h0);
   // low-time counters, so pulse length is checked without long repetition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rlow_q <= 11'h000;
         ilow_q <= 11'h000;
      end else begin
         rlow_q <= dog_reset_out_n ? 11'h000 : rlow_q + 11'h001;
         ilow_q <= dog_irq_out_n ? 11'h000 : ilow_q + 11'h001;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rst_pulse; $rose(dog_reset_out_n) |-> rlow_q == PULSE_CYC; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse length wrong");
   property p_irq_pulse; $rose(dog_irq_out_n) |-> ilow_q == PULSE_CYC; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse length wrong");
   property p_irq_no_rst; $fell(dog_irq_out_n) |-> dog_reset_out_n; endproperty
   a_irq_no_rst: assert property (p_irq_no_rst) else $error("reset beside irq");
   property p_slverr; pslverr == (psel && penable && unmap); endproperty
   a_slverr: assert property (p_slverr) else $error("slave error wrong");
   property p_unmap_zero; rd_set && unmap |=> prdata == 32'h0; endproperty
   a_unmap_zero: assert property (p_unmap_zero) else $error("unmapped read not zero");
   property p_chk_zero; rd_set && paddr == 12'h004 |=> prdata[5:3] == 3'h0; endproperty
   a_chk_zero: assert property (p_chk_zero) else $error("check field not zero");
   property p_stat_lvl;
      rd_set && paddr == 12'h000 |=> prdata[2] == $past(dog_irq_out_n, 3);
   endproperty
   a_stat_lvl: assert property (p_stat_lvl) else $error("irq level status lag wrong");
   property p_flag_hold; rd_set && paddr == 12'h004 && !device_reset_in_n |=> !prdata[7]; endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag set under pin reset");
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// testbench: apb scenarios for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        pclk = 1'b0;              // 250 MHz
   logic        presetn = 1'b0;           // block reset
   logic        device_reset_in_n = 1'b0; // pin held low with reset, so flag starts at 0
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        dog_reset_out_n;
   logic        dog_irq_out_n;
   logic [7:0]  dog_count;
   logic [31:0] rd;                       // last read data
   logic        er;                       // last slave error
   int          err_total = 0;
   int          total_checks = 0;
   int          cyc = 0;                  // timeout counter
   int          n;                        // pulse length
   always #2 pclk = ~pclk;
   // short pulse keeps the run brief
   wdc_top #(.PULSE_CYC(8)) dut_u (.pclk(pclk), .presetn(presetn),
      .device_reset_in_n(device_reset_in_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dog_reset_out_n(dog_reset_out_n), .dog_irq_out_n(dog_irq_out_n),
      .dog_count(dog_count));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // bad control word while enabled, pulse length measured in edges
   task bad_write;
      apb(1'b1, 12'h004, 32'h07);
      while (dog_reset_out_n !== 1'b0) @(posedge pclk);
      n = 0;
      while (dog_reset_out_n !== 1'b1) begin
         chk("irq idle", {31'h0, dog_irq_out_n}, 32'h1);
         @(posedge pclk);
         n++;
      end
      chk("reset pulse", n, 32'd8);
      repeat (12) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      device_reset_in_n <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("status reset", rd, 32'h5);
      apb(1'b0, 12'h004, 32'h0);
      chk("control reset", rd, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk("unprotected write", rd, 32'h5);
      $display("reset and protection test done");
      apb(1'b1, 12'h010, 32'h1);
      apb(1'b1, 12'h004, 32'h6f);
      apb(1'b0, 12'h004, 32'h0);
      chk("disable set", rd, 32'h47);
      apb(1'b1, 12'h004, 32'h47);
      apb(1'b0, 12'h004, 32'h0);
      chk("bad check while off", {31'h0, dog_reset_out_n}, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk("unlock write zero", rd, 32'h5);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk("unlock cleared", rd, 32'h4);
      apb(1'b0, 12'h004, 32'h0);
      chk("re-enabled", rd & 32'h40, 32'h0);
      apb(1'b1, 12'h004, 32'h6f);
      apb(1'b0, 12'h004, 32'h0);
      chk("disable locked", rd & 32'h40, 32'h0);
      $display("unlock test done");
      bad_write();
      chk("flag set", rd & 32'h80, 32'h80);
      apb(1'b1, 12'h004, 32'h2f);
      apb(1'b0, 12'h004, 32'h0);
      chk("flag write zero", rd & 32'h80, 32'h80);
      apb(1'b1, 12'h004, 32'haf);
      apb(1'b0, 12'h004, 32'h0);
      chk("flag cleared", rd, 32'h07);
      $display("flag test done");
      apb(1'b1, 12'h00c, 32'h55);
      apb(1'b1, 12'h00c, 32'haa);
      apb(1'b0, 12'h008, 32'h0);
      chk("count cleared", rd, 32'h0);
      chk("count port", {24'h0, dog_count}, 32'h0);
      chk("no reset on good key", {31'h0, dog_reset_out_n}, 32'h1);
      $display("key test done");
      apb(1'b1, 12'h000, 32'h2);
      apb(1'b1, 12'h00c, 32'h32);
      while (dog_irq_out_n !== 1'b0) @(posedge pclk);
      chk("no reset in irq mode", {31'h0, dog_reset_out_n}, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk("irq level low", rd, 32'h2);
      while (dog_irq_out_n !== 1'b1) @(posedge pclk);
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk("irq level high", rd, 32'h6);
      $display("irq test done");
      device_reset_in_n <= 1'b0;
      bad_write();
      chk("flag under pin reset", rd & 32'h80, 32'h0);
      device_reset_in_n <= 1'b1;
      apb(1'b1, 12'h014, 32'hff);
      apb(1'b0, 12'h014, 32'h0);
      chk("unmapped data", rd, 32'h0);
      chk("unmapped error", {31'h0, er}, 32'h1);
      $display("pin reset and unmapped test done");
      print_verdict();
   end
endmodule
bind wdc_top wdc_assertions #(.PULSE_CYC(PULSE_CYC)) chk_u (.pclk(pclk), .presetn(presetn),
   .device_reset_in_n(device_reset_in_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .dog_reset_out_n(dog_reset_out_n), .dog_irq_out_n(dog_irq_out_n), .dog_count(dog_count));
`default_nettype wire
